// file: core/fplc_core.sv
// Fan duty value, PWM divider and temperature table stepping logic.
`timescale 1ns/10ps
`default_nettype none
module fplc_core #(
   parameter int MCLK_LOW_CYC_P = fplc_pkg::MCLK_LOW_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data,
   input wire logic direct_write_en,
   input wire logic mclk_select_low,
   input wire logic spinup_active,
   input wire logic [fplc_pkg::TEMP_W-1:0] remote_temp,
   input wire logic [fplc_pkg::ENTRIES*fplc_pkg::ENTRY_T_W-1:0] table_temp_flat,
   input wire logic [fplc_pkg::ENTRIES*fplc_pkg::DUTY_W-1:0] table_duty_flat,
   input wire logic fan_pwm_in,
   output logic fan_pwm_out,
   output logic fan_pwm_oe
);
   import fplc_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic [DUTY_W-1:0] duty_man_q;
   logic [DIV_W-1:0] div_q;
   logic [OFS_W-1:0] ofs_q;
   logic [HYST_W-1:0] hyst_q;
   logic [7:0] rd_data_q;
   logic [LVL_W-1:0] lvl_q;
   logic [LVL_W-1:0] target;
   logic release_ok;
   logic [DUTY_W-1:0] lut_duty;
   logic [DUTY_W-1:0] act_duty;
   logic [TEMP_W-1:0] thr [ENTRIES];
   logic [ENTRIES-1:0] exceed;
   logic [MCLK_CNT_W-1:0] mclk_cnt_q;
   logic [MCLK_CNT_W-1:0] mclk_lim;
   logic mtick;
   logic [5:0] phase_q;
   logic [5:0] period;
   logic [11:0] high_lim;
   logic oe_q;
   logic pin_out_q;
   logic wr_duty;

   assign reg_rd_data = rd_data_q;
   assign fan_pwm_out = pin_out_q;
   assign fan_pwm_oe = oe_q;

   // -------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------
   assign wr_duty = reg_wr_en && direct_write_en && hit(reg_addr, FAN_DUTY_VALUE_OFS);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         duty_man_q <= DUTY_RST;
      end else if (wr_duty) begin
         duty_man_q <= reg_wr_data[DUTY_W-1:0]; // [RQ2]
      end
   end

   // Only the low field bits are stored, so upper bits drop writes.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_q <= DIV_RST;
         ofs_q <= OFS_RST;
         hyst_q <= HYST_RST; // [RQ11]
      end else if (reg_wr_en) begin
         if (hit(reg_addr, FAN_OUTPUT_FREQUENCY_OFS)) begin
            div_q <= reg_wr_data[DIV_W-1:0]; // [RQ4]
         end
         if (hit(reg_addr, TABLE_TEMPERATURE_OFFSET_OFS)) begin
            ofs_q <= reg_wr_data[OFS_W-1:0]; // [RQ4] [RQ9]
         end
         if (hit(reg_addr, TABLE_HYSTERESIS_OFS)) begin
            hyst_q <= reg_wr_data[HYST_W-1:0]; // [RQ4] [RQ10]
         end
      end
   end

   // -------------------------------------------------------------
   // Register reads
   // -------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data_q <= 8'h00;
      end else if (reg_rd_en) begin
         if (hit(reg_addr, FAN_DUTY_VALUE_OFS)) begin
            rd_data_q <= spinup_active ? 8'h00 : {2'h0, act_duty}; // [RQ1] [RQ3]
         end else if (hit(reg_addr, FAN_OUTPUT_FREQUENCY_OFS)) begin
            rd_data_q <= {3'h0, div_q}; // [RQ4]
         end else if (hit(reg_addr, TABLE_TEMPERATURE_OFFSET_OFS)) begin
            rd_data_q <= {2'h0, ofs_q}; // [RQ4]
         end else if (hit(reg_addr, TABLE_HYSTERESIS_OFS)) begin
            rd_data_q <= {3'h0, hyst_q}; // [RQ4]
         end else begin
            rd_data_q <= 8'h00;
         end
      end
   end

   // -------------------------------------------------------------
   // Temperature table stepping
   // -------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < ENTRIES; gi++) begin : g_thr
         assign thr[gi] = {1'b0, table_temp_flat[gi*ENTRY_T_W +: ENTRY_T_W]}
                          + {2'h0, ofs_q}; // [RQ8]
         assign exceed[gi] = remote_temp > thr[gi]; // [RQ12]
      end
   endgenerate

   // Level 0 means no entry exceeded; level k means entry k-1.
   always_comb begin
      target = '0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (exceed[i]) begin
            target = LVL_W'(i + 1);
         end
      end
   end

   // The level only falls once the temperature clears the band below its entry.
   always_comb begin
      release_ok = 1'b1;
      lut_duty = '0;
      if (lvl_q != '0) begin
         release_ok = ({1'b0, remote_temp} + {4'h0, hyst_q})
                      < {1'b0, thr[lvl_q - 1'b1]}; // [RQ13] [RQ10]
         lut_duty = table_duty_flat[(lvl_q - 1'b1)*DUTY_W +: DUTY_W]; // [RQ12]
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lvl_q <= '0;
      end else if (target > lvl_q) begin
         lvl_q <= target; // [RQ12]
      end else if (target < lvl_q && release_ok) begin
         lvl_q <= target; // [RQ13]
      end
   end

   assign act_duty = direct_write_en ? duty_man_q : lut_duty; // [RQ1] [RQ2]

   // -------------------------------------------------------------
   // Master clock and PWM output
   // -------------------------------------------------------------
   assign mclk_lim = mclk_select_low ? MCLK_CNT_W'(MCLK_LOW_CYC_P - 1)
                                     : MCLK_CNT_W'(MCLK_HIGH_CYC - 1); // [RQ6]
   assign mtick = (mclk_cnt_q >= mclk_lim);
   assign period = (div_q == '0) ? 6'h02 : {div_q, 1'b0}; // [RQ5] [RQ7]
   // Both factors are widened first so the product keeps all twelve bits.
   assign high_lim = 12'(act_duty) * 12'(period);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mclk_cnt_q <= '0;
      end else if (mtick) begin
         mclk_cnt_q <= '0; // [RQ6]
      end else begin
         mclk_cnt_q <= mclk_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phase_q <= '0;
      end else if (mtick) begin
         phase_q <= (phase_q >= period - 1'b1) ? 6'h00 : phase_q + 1'b1; // [RQ5]
      end
   end

   // The pin is released while the duty is high and pulled low otherwise.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         oe_q <= 1'b1;
         pin_out_q <= 1'b0;
      end else begin
         oe_q <= !({phase_q, 6'h00} < high_lim); // [RQ5]
         pin_out_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   sequence s_duty_read;
      reg_rd_en && hit(reg_addr, FAN_DUTY_VALUE_OFS);
   endsequence

   sequence s_rsvd_read;
      reg_rd_en && (hit(reg_addr, FAN_OUTPUT_FREQUENCY_OFS)
         || hit(reg_addr, TABLE_HYSTERESIS_OFS));
   endsequence

   a_ro_duty_read: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ1]
      s_duty_read ##0 (!direct_write_en && !spinup_active)
      |=> rd_data_q == {2'h0, $past(lut_duty)})
      else $error("Duty read does not show table result.");

   a_dw_duty_store: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ2]
      wr_duty |=> duty_man_q == $past(reg_wr_data[5:0]) ##1 (!direct_write_en
      || act_duty == duty_man_q))
      else $error("Direct duty write not stored or not used.");

   a_spin_read_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ3]
      s_duty_read ##0 spinup_active |=> rd_data_q == 8'h00)
      else $error("Duty read not zero during spin-up.");

   a_rsvd_bits_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ4]
      s_rsvd_read |=> rd_data_q[7:5] == 3'h0)
      else $error("Unused register bits read nonzero.");

   a_pwm_phase_wrap: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ5]
      mtick && phase_q == period - 1'b1 && $stable(div_q) |=> phase_q == 6'h00)
      else $error("PWM phase did not wrap at twice the divisor.");

   a_mclk_tick_gap: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ6]
      mtick && !mclk_select_low ##1 !mclk_select_low [*8]
      |-> mclk_cnt_q == 18'h00007)
      else $error("Master clock counter not restarted on tick.");

   a_div_zero_one: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ7]
      div_q == 5'h00 |-> period == 6'h02)
      else $error("Divisor zero not treated as one.");

   a_lut_step_up: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ12]
      target > lvl_q |=> lvl_q == $past(target))
      else $error("Table level did not rise to exceeded entry.");

   a_hyst_hold_step: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ13]
      target < lvl_q && !release_ok |=> lvl_q == $past(lvl_q))
      else $error("Table level dropped inside hysteresis band.");

   a_hyst_release: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ13]
      target < lvl_q && release_ok |=> lvl_q == $past(target))
      else $error("Table level held below the hysteresis band.");

   a_lvl_bound: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ12]
      lvl_q <= LVL_W'(ENTRIES))
      else $error("Table level points past the last entry.");

   // -------------------------------------------------------------
   // Register store and guard checks
   // -------------------------------------------------------------
   // A duty write is only taken while direct write is on.
   sequence s_duty_blocked_write;
      reg_wr_en && !direct_write_en && hit(reg_addr, FAN_DUTY_VALUE_OFS);
   endsequence

   sequence s_ofs_read;
      reg_rd_en && hit(reg_addr, TABLE_TEMPERATURE_OFFSET_OFS);
   endsequence

   a_duty_write_guard: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ1]
      s_duty_blocked_write |=> duty_man_q == $past(duty_man_q))
      else $error("Duty write taken while direct write was off.");

   a_dw_duty_read: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ2]
      s_duty_read ##0 (direct_write_en && !spinup_active)
      |=> rd_data_q == {2'h0, $past(duty_man_q)})
      else $error("Duty read does not show the written value.");

   a_ofs_bits_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ4]
      s_ofs_read |=> rd_data_q[7:6] == 2'h0)
      else $error("Unused offset register bits read nonzero.");

   a_ofs_store: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ9]
      reg_wr_en && hit(reg_addr, TABLE_TEMPERATURE_OFFSET_OFS)
      |=> ofs_q == $past(reg_wr_data[5:0]))
      else $error("Table offset write not stored.");

   a_hyst_store: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ10]
      reg_wr_en && hit(reg_addr, TABLE_HYSTERESIS_OFS)
      |=> hyst_q == $past(reg_wr_data[4:0]))
      else $error("Hysteresis write not stored.");

   // -------------------------------------------------------------
   // Master clock and PWM checks
   // -------------------------------------------------------------
   a_pwm_phase_step: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ5]
      mtick && phase_q < period - 1'b1 |=> phase_q == $past(phase_q) + 1'b1)
      else $error("PWM phase did not advance on master tick.");

   a_zero_duty_low: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ5]
      act_duty == '0 |=> fan_pwm_oe)
      else $error("Fan pin released with zero duty.");

   a_mclk_count_up: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ6]
      !mtick |=> mclk_cnt_q == $past(mclk_cnt_q) + 1'b1)
      else $error("Master clock counter skipped a cycle.");

   a_mclk_high_bound: assert property (@(posedge core_clk) disable iff (sys_rst) // [RQ6]
      !mclk_select_low && !$past(mclk_select_low)
      |-> mclk_cnt_q <= MCLK_CNT_W'(MCLK_HIGH_CYC - 1))
      else $error("Fast master clock counter ran past its limit.");
endmodule : fplc_core
`default_nettype wire

// file: common/fplc_pkg.sv
// Constants for the fan duty, PWM frequency and temperature table block.
// What this block does
// RQ1 - Duty reads table result unless direct-write
// RQ2 - Direct-write makes duty writable, drives fan
// RQ3 - Duty reads zero during spin-up
// RQ4 - Unused upper bits ignore writes, read zero
// RQ5 - Fan frequency is master clock over 2n
// RQ6 - Select bit picks 360 kHz or 1.4 kHz
// RQ7 - Divisor zero behaves as divisor one
// RQ8 - Offset added to every table threshold
// RQ9 - Offset unsigned, 1 degree steps, max 63
// RQ10 - Hysteresis 5 bits, 1 degree per count
// RQ11 - Hysteresis reset conflict resolved to 0x04
// RQ12 - Temperature above threshold selects paired duty
// RQ13 - Keep step until below threshold minus hysteresis
package fplc_pkg;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] FAN_DUTY_VALUE_OFS = 8'h4C;
   localparam logic [7:0] FAN_OUTPUT_FREQUENCY_OFS = 8'h4D;
   localparam logic [7:0] TABLE_TEMPERATURE_OFFSET_OFS = 8'h4E;
   localparam logic [7:0] TABLE_HYSTERESIS_OFS = 8'h4F;
   // -------------------------------------------------------------
   // Field widths and reset values
   // -------------------------------------------------------------
   localparam int DUTY_W = 6;
   localparam int DIV_W = 5;
   localparam int OFS_W = 6;
   localparam int HYST_W = 5;
   localparam int TEMP_W = 8;
   localparam int ENTRY_T_W = 7;
   localparam int ENTRIES = 12;
   localparam int LVL_W = 4;
   localparam logic [5:0] DUTY_RST = 6'h00;
   localparam logic [4:0] DIV_RST = 5'h17;
   localparam logic [5:0] OFS_RST = 6'h00;
   localparam logic [4:0] HYST_RST = 5'h04;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CORE_CLK_HZ = 200_000_000;
   localparam int PWM_MCLK_HIGH_HZ = 360_000;
   localparam int PWM_MCLK_LOW_HZ = 1_400;
   localparam int MCLK_HIGH_CYC = CORE_CLK_HZ / PWM_MCLK_HIGH_HZ;
   localparam int MCLK_LOW_CYC = CORE_CLK_HZ / PWM_MCLK_LOW_HZ;
   localparam int MCLK_CNT_W = 18;
endpackage : fplc_pkg

// file: testbench/fplc_fan_model.sv
// Fan model: pulled-up open-drain pin and a period meter.
`timescale 1ns/10ps
`default_nettype none
module fplc_fan_model (
   input wire logic core_clk,
   input wire logic pwm_out,
   input wire logic pwm_oe,
   output logic pin,
   output logic [15:0] period
);
   logic [15:0] cnt_q;
   logic pin_q;
   // The fan's pull-up lifts the pin whenever the block lets go of it.
   assign pin = pwm_oe ? pwm_out : 1'b1;
   always_ff @(posedge core_clk) begin
      pin_q <= pin;
      cnt_q <= (pin && !pin_q) ? 16'h0001 : cnt_q + 16'h0001;
      if (pin && !pin_q) begin
         period <= cnt_q;
      end
   end
endmodule : fplc_fan_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the fan duty, frequency and table block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fplc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic dwe = 1'b0;
   logic msel = 1'b1;
   logic spin = 1'b0;
   logic oe, pout, pin;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] temp = 8'h00;
   logic [7:0] rdata;
   logic [83:0] thr_flat = {12{7'h7F}};
   logic [71:0] duty_flat = {12{6'h3F}};
   logic [15:0] period;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   fplc_core #(.MCLK_LOW_CYC_P(20)) fplc_core_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(rd_en),
      .reg_rd_data(rdata), .direct_write_en(dwe), .mclk_select_low(msel),
      .spinup_active(spin), .remote_temp(temp), .table_temp_flat(thr_flat),
      .table_duty_flat(duty_flat), .fan_pwm_in(pin), .fan_pwm_out(pout), .fan_pwm_oe(oe));
   fplc_fan_model fplc_fan_model_i (.core_clk(core_clk), .pwm_out(pout), .pwm_oe(oe),
      .pin(pin), .period(period));
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         results();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge core_clk);
      rd_en = 1'b0;
      chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, rdata});
   endtask : rd
   // Sets the temperature and lets the table step settle.
   task automatic heat(input logic [7:0] t, input logic [7:0] exp);
      temp = t;
      repeat (3) @(negedge core_clk);
      rd(FAN_DUTY_VALUE_OFS, exp);
   endtask : heat
   // Several periods pass so a divisor change mid-period is flushed out.
   task automatic per(input logic [7:0] n, input logic [15:0] exp);
      wr(FAN_OUTPUT_FREQUENCY_OFS, n);
      repeat (4 * exp + 100) @(negedge core_clk);
      chk("pwm period", exp, period);
   endtask : per
   task automatic results;
      $display("Checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   initial begin
      thr_flat[6:0] = 7'h28;
      duty_flat[5:0] = 6'h0A;
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      rd(FAN_DUTY_VALUE_OFS, 8'h00);
      rd(FAN_OUTPUT_FREQUENCY_OFS, 8'h17);
      rd(TABLE_TEMPERATURE_OFFSET_OFS, 8'h00);
      rd(TABLE_HYSTERESIS_OFS, 8'h04);
      rd(8'h40, 8'h00);
      wr(FAN_OUTPUT_FREQUENCY_OFS, 8'hFF);
      wr(TABLE_TEMPERATURE_OFFSET_OFS, 8'hFF);
      wr(TABLE_HYSTERESIS_OFS, 8'hFF);
      rd(FAN_OUTPUT_FREQUENCY_OFS, 8'h1F);
      rd(TABLE_TEMPERATURE_OFFSET_OFS, 8'h3F);
      rd(TABLE_HYSTERESIS_OFS, 8'h1F);
      wr(TABLE_TEMPERATURE_OFFSET_OFS, 8'h00);
      wr(TABLE_HYSTERESIS_OFS, 8'h04);
      $display("Test registers done");
      wr(FAN_DUTY_VALUE_OFS, 8'h33);
      heat(8'd45, 8'h0A);
      heat(8'd38, 8'h0A);
      heat(8'd35, 8'h00);
      heat(8'd45, 8'h0A);
      wr(TABLE_TEMPERATURE_OFFSET_OFS, 8'h0A);
      heat(8'd45, 8'h00);
      heat(8'd51, 8'h0A);
      $display("Test table done");
      dwe = 1'b1;
      wr(FAN_DUTY_VALUE_OFS, 8'hE0);
      rd(FAN_DUTY_VALUE_OFS, 8'h20);
      spin = 1'b1;
      rd(FAN_DUTY_VALUE_OFS, 8'h00);
      spin = 1'b0;
      $display("Test duty done");
      per(8'h01, 16'd40);
      per(8'h00, 16'd40);
      per(8'h03, 16'd120);
      msel = 1'b0;
      per(8'h01, 16'd1110);
      $display("Test frequency done");
      sys_rst = 1'b1;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      rd(FAN_OUTPUT_FREQUENCY_OFS, 8'h17);
      rd(TABLE_HYSTERESIS_OFS, 8'h04);
      rd(FAN_DUTY_VALUE_OFS, 8'h00);
      $display("Test reset done");
      results();
   end
endmodule : tb_top
`default_nettype wire
